// *** nfc_pkg.sv ***
// Package of constants and types for the parallel NOR flash host controller.
// Assumes one synchronous clock domain; flash pin levels are handled outside.
//
// Summary of operation
// - Address bits 19 to 12 carry the sector for erase and protection query.
// - Every command cycle is a write except plain read and final identification read.
// - Write F0 anywhere returns to array read; used after timeout flag rises.
// - Identification: 555/AA, 2AA/55, 555/90, then read word 00, 01, sector/02 or 03.
// - Secured region entry ends 555/88; exit is unlock, 555/90, then 00.
// - Parameter query is 98 at word 55, only in array-read or identification.
// - Program: 555/AA, 2AA/55, 555/A0, then location with value.
// - Bypass entered with 555/20; bypass program is A0 then location/value.
// - Bypass left by 90 then 00, or by F0.
// - Erase: six writes; 555/10 erases chip, sector/30 erases sector.
`default_nettype none

package nfc_pkg;

  typedef enum logic [3:0] {
    CMD_READ, CMD_RESET, CMD_ID_READ, CMD_SECURE_ENTER, CMD_SECURE_EXIT, CMD_QUERY,
    CMD_PROGRAM, CMD_BYPASS_ENTER, CMD_BYPASS_PROGRAM, CMD_BYPASS_EXIT,
    CMD_CHIP_ERASE, CMD_SECTOR_ERASE, CMD_SUSPEND, CMD_RESUME
  } nfc_cmd_t;

  typedef enum logic [1:0] {MODE_READ, MODE_ID, MODE_QUERY, MODE_BYPASS} nfc_mode_t;

  // Widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // Command cycle addresses
  localparam logic [19:0] ADDR_UNLOCK1 = 20'h00555;
  localparam logic [19:0] ADDR_UNLOCK2 = 20'h002aa;
  localparam logic [19:0] ADDR_QUERY   = 20'h00055;
  localparam logic [19:0] ADDR_ANY     = 20'h00000;
  localparam logic [19:0] SECTOR_MASK  = 20'hff000;
  localparam int          SECTOR_LSB   = 12;
  localparam int          SECTOR_MSB   = 19;
  localparam int          CMD_ADDR_MSB = 11;

  // Identification word offsets
  localparam logic [19:0] ID_MAKER   = 20'h00000;
  localparam logic [19:0] ID_PART    = 20'h00001;
  localparam logic [19:0] ID_PROTECT = 20'h00002;
  localparam logic [19:0] ID_LOCK    = 20'h00003;

  // Command data, upper byte zero
  localparam logic [15:0] CD_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] CD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CD_AUTOSEL = 16'h0090;
  localparam logic [15:0] CD_EXIT    = 16'h0000;
  localparam logic [15:0] CD_RESET   = 16'h00f0;
  localparam logic [15:0] CD_SECURE  = 16'h0088;
  localparam logic [15:0] CD_QUERY   = 16'h0098;
  localparam logic [15:0] CD_PROGRAM = 16'h00a0;
  localparam logic [15:0] CD_BYPASS  = 16'h0020;
  localparam logic [15:0] CD_ERASE   = 16'h0080;
  localparam logic [15:0] CD_CHIP    = 16'h0010;
  localparam logic [15:0] CD_SECTOR  = 16'h0030;
  localparam logic [15:0] CD_SUSPEND = 16'h00b0;
  localparam logic [15:0] CD_RESUME  = 16'h0030;

  // Timing
  localparam int CLK_NS      = 20;
  localparam int T_SETUP_NS  = 20;
  localparam int T_PULSE_NS  = 50;
  localparam int T_HOLD_NS   = 20;
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC  = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);

endpackage

`default_nettype wire

// *** nfc_bus_cycle.sv ***
// One write or read cycle on the flash pins, write or output enable controlled.
// Assumes pins reach the flash through pad logic outside; inputs synchronous.
`default_nettype none

module nfc_bus_cycle (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        isWrite,
  input  wire logic [19:0] addrIn,
  input  wire logic [15:0] dataIn,
  output logic             idle,
  output logic             done,
  output logic [15:0]      readData,
  output logic [19:0]      flashAddr,
  output logic [15:0]      dqOut,
  output logic             dqDriveN,
  input  wire logic [15:0] dqIn,
  output logic             ceN,
  output logic             weN,
  output logic             oeN
);
  import nfc_pkg::*;

  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_RECOVER} nfc_bc_state_t;

  nfc_bc_state_t state_q;
  logic [3:0]    cnt_q;
  logic          wr_q;
  logic [19:0]   addr_q;
  logic [15:0]   dout_q;
  logic [15:0]   rdata_q;
  logic          ce_q, we_q, oe_q, drv_q, done_q;

  wire cntEnd = (cnt_q == 4'h1);

  // ==========================================================
  // Cycle sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= BC_IDLE;
      cnt_q   <= 4'h0;
      wr_q    <= 1'b0;
      addr_q  <= 20'h00000;
      dout_q  <= 16'h0000;
      rdata_q <= 16'h0000;
      ce_q    <= 1'b1;
      we_q    <= 1'b1;
      oe_q    <= 1'b1;
      drv_q   <= 1'b1;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        BC_IDLE: begin
          if (start) begin
            state_q <= BC_SETUP;
            cnt_q   <= SETUP_CYC;
            wr_q    <= isWrite;
            addr_q  <= addrIn;
            dout_q  <= dataIn;
            ce_q    <= 1'b0;
            drv_q   <= !isWrite;
          end
        end
        BC_SETUP: begin
          if (cntEnd) begin
            state_q <= BC_STROBE;
            cnt_q   <= PULSE_CYC;
            we_q    <= !wr_q;
            oe_q    <= wr_q;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        BC_STROBE: begin
          if (cntEnd) begin
            state_q <= BC_RECOVER;
            cnt_q   <= HOLD_CYC;
            we_q    <= 1'b1;
            oe_q    <= 1'b1;
            if (!wr_q) begin
              rdata_q <= dqIn;
            end
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        BC_RECOVER: begin
          if (cntEnd) begin
            state_q <= BC_IDLE;
            ce_q    <= 1'b1;
            drv_q   <= 1'b1;
            done_q  <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  assign idle      = (state_q == BC_IDLE);
  assign done      = done_q;
  assign readData  = rdata_q;
  assign flashAddr = addr_q;
  assign dqOut     = dout_q;
  assign dqDriveN  = drv_q;
  assign ceN       = ce_q;
  assign weN       = we_q;
  assign oeN       = oe_q;

  // ==========================================================
  // Checks
  a_addr_before_we: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(weN) |-> !$past(ceN) && $stable(flashAddr) && !dqDriveN)
    else $error("write strobe fell without chip select and stable address");

  a_data_after_we: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(weN) |-> !ceN && !dqDriveN && $stable(dqOut) ##1 (ceN && dqDriveN))
    else $error("write data released before write strobe rose");

  a_strobe_width: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(weN) |-> !weN[*3] ##1 weN)
    else $error("write strobe pulse width wrong");

endmodule // nfc_bus_cycle

`default_nettype wire

// *** nfc_flash_host.sv ***
// Host controller that sequences flash command cycles from user requests.
// Assumes a single flash on the pins; ready and timeout inputs synchronous.
`default_nettype none

module nfc_flash_host (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            cmdValid,
  output logic                 cmdReady,
  input  wire nfc_pkg::nfc_cmd_t cmdCode,
  input  wire logic [19:0]     cmdAddr,
  input  wire logic [15:0]     cmdData,
  output logic                 rspValid,
  output logic                 rspError,
  output logic [15:0]          rspData,
  output nfc_pkg::nfc_mode_t   modeState,
  output logic                 eraseRunning,
  output logic                 eraseSuspended,
  output logic                 secureRegion,
  input  wire logic            flashReady,
  input  wire logic            timeoutExceeded,
  output logic [19:0]          flashAddr,
  output logic [15:0]          dqOut,
  output logic                 dqDriveN,
  input  wire logic [15:0]     dqIn,
  output logic                 ceN,
  output logic                 weN,
  output logic                 oeN
);
  import nfc_pkg::*;

  typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_WAIT} nfc_host_state_t;

  // ==========================================================
  // Sequence tables
  function automatic logic [36:0] wrStep(input logic [19:0] a, input logic [15:0] d);
    wrStep = {1'b1, a, d};
  endfunction

  function automatic logic [36:0] stepOf(input nfc_cmd_t c, input logic [2:0] i,
                                         input logic [19:0] a, input logic [15:0] d);
    logic [36:0] u1, u2, rdA;
    u1  = wrStep(ADDR_UNLOCK1, CD_UNLOCK1);
    u2  = wrStep(ADDR_UNLOCK2, CD_UNLOCK2);
    rdA = {1'b0, a, 16'h0000};
    unique case (c)
      CMD_READ:           stepOf = rdA;
      CMD_RESET:          stepOf = wrStep(ADDR_ANY, CD_RESET);
      CMD_ID_READ:        stepOf = (i == 3'd0) ? u1 : (i == 3'd1) ? u2 :
                                   (i == 3'd2) ? wrStep(ADDR_UNLOCK1, CD_AUTOSEL) : rdA;
      CMD_SECURE_ENTER:   stepOf = (i == 3'd0) ? u1 : (i == 3'd1) ? u2 :
                                   wrStep(ADDR_UNLOCK1, CD_SECURE);
      CMD_SECURE_EXIT:    stepOf = (i == 3'd0) ? u1 : (i == 3'd1) ? u2 :
                                   (i == 3'd2) ? wrStep(ADDR_UNLOCK1, CD_AUTOSEL) :
                                   wrStep(ADDR_ANY, CD_EXIT);
      CMD_QUERY:          stepOf = wrStep(ADDR_QUERY, CD_QUERY);
      CMD_PROGRAM:        stepOf = (i == 3'd0) ? u1 : (i == 3'd1) ? u2 :
                                   (i == 3'd2) ? wrStep(ADDR_UNLOCK1, CD_PROGRAM) :
                                   wrStep(a, d);
      CMD_BYPASS_ENTER:   stepOf = (i == 3'd0) ? u1 : (i == 3'd1) ? u2 :
                                   wrStep(ADDR_UNLOCK1, CD_BYPASS);
      CMD_BYPASS_PROGRAM: stepOf = (i == 3'd0) ? wrStep(ADDR_ANY, CD_PROGRAM) :
                                   wrStep(a, d);
      CMD_BYPASS_EXIT:    stepOf = (i == 3'd0) ? wrStep(ADDR_ANY, CD_AUTOSEL) :
                                   wrStep(ADDR_ANY, CD_EXIT);
      CMD_CHIP_ERASE, CMD_SECTOR_ERASE: begin
        if (i == 3'd0 || i == 3'd3) begin
          stepOf = u1;
        end else if (i == 3'd1 || i == 3'd4) begin
          stepOf = u2;
        end else if (i == 3'd2) begin
          stepOf = wrStep(ADDR_UNLOCK1, CD_ERASE);
        end else if (c == CMD_CHIP_ERASE) begin
          stepOf = wrStep(ADDR_UNLOCK1, CD_CHIP);
        end else begin
          stepOf = wrStep(a & SECTOR_MASK, CD_SECTOR);
        end
      end
      CMD_SUSPEND:        stepOf = wrStep(ADDR_ANY, CD_SUSPEND);
      CMD_RESUME:         stepOf = wrStep(ADDR_ANY, CD_RESUME);
      default:            stepOf = wrStep(ADDR_ANY, CD_RESET);
    endcase
  endfunction

  function automatic logic [2:0] lenOf(input nfc_cmd_t c);
    unique case (c)
      CMD_ID_READ, CMD_SECURE_EXIT, CMD_PROGRAM:       lenOf = 3'd4;
      CMD_SECURE_ENTER, CMD_BYPASS_ENTER:              lenOf = 3'd3;
      CMD_BYPASS_PROGRAM, CMD_BYPASS_EXIT:             lenOf = 3'd2;
      CMD_CHIP_ERASE, CMD_SECTOR_ERASE:                lenOf = 3'd6;
      default:                                         lenOf = 3'd1;
    endcase
  endfunction

  // ==========================================================
  // State
  nfc_host_state_t state_q;
  nfc_cmd_t        cmd_q;
  nfc_mode_t       mode_q;
  logic [2:0]      idx_q;
  logic [19:0]     addr_q;
  logic [15:0]     data_q;
  logic            internal_q, pend_q, toPrev_q, rdyPrev_q;
  logic            eraseRun_q, sectorKind_q, susp_q, secure_q;
  logic [7:0]      eraseSec_q;
  logic            rspValid_q, rspErr_q;
  logic [15:0]     rspData_q;

  // ==========================================================
  // Decode of request legality
  wire        busy       = eraseRun_q && !susp_q;
  wire        sameSector = susp_q && (cmdAddr[SECTOR_MSB:SECTOR_LSB] == eraseSec_q);
  wire        inRead     = (mode_q == MODE_READ);
  wire        inBypass   = (mode_q == MODE_BYPASS);
  logic       legal;
  always_comb begin
    unique case (cmdCode)
      CMD_RESET:          legal = 1'b1;
      CMD_READ:           legal = !sameSector;
      CMD_SUSPEND:        legal = busy && sectorKind_q;
      CMD_RESUME:         legal = susp_q;
      CMD_QUERY:          legal = !busy && (inRead || mode_q == MODE_ID);
      CMD_ID_READ:        legal = !busy && (inRead || mode_q == MODE_ID);
      CMD_PROGRAM:        legal = inRead && !busy && !sameSector;
      CMD_BYPASS_PROGRAM: legal = inBypass && !busy && !sameSector;
      CMD_BYPASS_EXIT:    legal = inBypass;
      default:            legal = inRead && !eraseRun_q;
    endcase
  end

  wire        accept   = cmdValid && cmdReady;
  wire [36:0] step     = stepOf(cmd_q, idx_q, addr_q, data_q);
  wire        stepWr   = step[36];
  wire [19:0] stepAddr = step[35:16];
  wire [15:0] stepData = step[15:0];
  wire        lastStep = (idx_q == lenOf(cmd_q) - 3'd1);
  wire        busStart = (state_q == HS_ISSUE);
  wire        busIdle;
  wire        busDone;
  wire [15:0] busRdata;
  wire        toRise   = timeoutExceeded && !toPrev_q;
  wire        rdyRise  = flashReady && !rdyPrev_q;
  wire        finish   = (state_q == HS_WAIT) && busDone && lastStep;
  wire        suspending = (state_q != HS_IDLE) && (cmd_q == CMD_SUSPEND);

  assign cmdReady = (state_q == HS_IDLE) && !pend_q;

  // ==========================================================
  // Request sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q    <= HS_IDLE;
      cmd_q      <= CMD_RESET;
      idx_q      <= 3'd0;
      addr_q     <= 20'h00000;
      data_q     <= 16'h0000;
      internal_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspErr_q   <= 1'b0;
      rspData_q  <= 16'h0000;
    end else begin
      rspValid_q <= 1'b0;
      unique case (state_q)
        HS_IDLE: begin
          idx_q <= 3'd0;
          if (pend_q) begin
            cmd_q      <= CMD_RESET;
            internal_q <= 1'b1;
            state_q    <= HS_ISSUE;
          end else if (accept && legal) begin
            cmd_q      <= cmdCode;
            addr_q     <= cmdAddr;
            data_q     <= cmdData;
            internal_q <= 1'b0;
            state_q    <= HS_ISSUE;
          end else if (accept) begin
            rspValid_q <= 1'b1;
            rspErr_q   <= 1'b1;
          end
        end
        HS_ISSUE: state_q <= HS_WAIT;
        HS_WAIT: begin
          if (busDone) begin
            if (lastStep) begin
              state_q    <= HS_IDLE;
              rspValid_q <= !internal_q;
              rspErr_q   <= 1'b0;
              rspData_q  <= stepWr ? 16'h0000 : busRdata;
            end else begin
              idx_q   <= idx_q + 3'd1;
              state_q <= HS_ISSUE;
            end
          end
        end
        default: state_q <= HS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Device mode tracking
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_q       <= MODE_READ;
      eraseRun_q   <= 1'b0;
      sectorKind_q <= 1'b0;
      susp_q       <= 1'b0;
      secure_q     <= 1'b0;
      eraseSec_q   <= 8'h00;
      pend_q       <= 1'b0;
      toPrev_q     <= 1'b0;
      rdyPrev_q    <= 1'b1;
    end else begin
      toPrev_q  <= timeoutExceeded;
      rdyPrev_q <= flashReady;
      if (toRise) begin
        pend_q <= 1'b1;
      end else if (state_q == HS_IDLE) begin
        pend_q <= 1'b0;
      end
      if (rdyRise && !susp_q && !suspending) begin
        eraseRun_q <= 1'b0;
      end
      if (finish) begin
        unique case (cmd_q)
          CMD_RESET:        mode_q <= MODE_READ;
          CMD_ID_READ:      mode_q <= MODE_ID;
          CMD_QUERY:        mode_q <= MODE_QUERY;
          CMD_BYPASS_ENTER: mode_q <= MODE_BYPASS;
          CMD_BYPASS_EXIT:  mode_q <= MODE_READ;
          CMD_SECURE_ENTER: secure_q <= 1'b1;
          CMD_SECURE_EXIT: begin
            secure_q <= 1'b0;
            mode_q   <= MODE_READ;
          end
          CMD_CHIP_ERASE: begin
            eraseRun_q   <= 1'b1;
            sectorKind_q <= 1'b0;
          end
          CMD_SECTOR_ERASE: begin
            eraseRun_q   <= 1'b1;
            sectorKind_q <= 1'b1;
            eraseSec_q   <= addr_q[SECTOR_MSB:SECTOR_LSB];
          end
          CMD_SUSPEND:      susp_q <= 1'b1;
          CMD_RESUME:       susp_q <= 1'b0;
          default:          mode_q <= mode_q;
        endcase
      end
    end
  end

  assign rspValid       = rspValid_q;
  assign rspError       = rspErr_q;
  assign rspData        = rspData_q;
  assign modeState      = mode_q;
  assign eraseRunning   = eraseRun_q;
  assign eraseSuspended = susp_q;
  assign secureRegion   = secure_q;

  // ==========================================================
  // Pin cycle engine
  nfc_bus_cycle u_cycle (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .start     (busStart),
    .isWrite   (stepWr),
    .addrIn    (stepAddr),
    .dataIn    (stepData),
    .idle      (busIdle),
    .done      (busDone),
    .readData  (busRdata),
    .flashAddr (flashAddr),
    .dqOut     (dqOut),
    .dqDriveN  (dqDriveN),
    .dqIn      (dqIn),
    .ceN       (ceN),
    .weN       (weN),
    .oeN       (oeN)
  );

  // ==========================================================
  // Checks
  wire carriesLoc = lastStep && (cmd_q == CMD_PROGRAM || cmd_q == CMD_BYPASS_PROGRAM ||
                                 cmd_q == CMD_SECTOR_ERASE);

  a_cmd_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
    busStart && stepWr && !carriesLoc |-> stepData[15:8] == 8'h00)
    else $error("command cycle drives nonzero upper data byte");

  a_cmd_addr_low: assert property (@(posedge clk_sys) disable iff (rst)
    busStart && stepWr && !carriesLoc |-> stepAddr[19:CMD_ADDR_MSB] == '0)
    else $error("command cycle drives upper address bits");

  a_sector_final: assert property (@(posedge clk_sys) disable iff (rst)
    busStart && cmd_q == CMD_SECTOR_ERASE && lastStep
      |-> stepAddr == (addr_q & SECTOR_MASK) && stepData == CD_SECTOR)
    else $error("sector erase final cycle malformed");

  a_suspend_gate: assert property (@(posedge clk_sys) disable iff (rst)
    accept && cmdCode == CMD_SUSPEND && !(eraseRun_q && !susp_q && sectorKind_q)
      |=> rspValid && rspError && busIdle)
    else $error("suspend not refused outside sector erase");

  a_resume_gate: assert property (@(posedge clk_sys) disable iff (rst)
    accept && cmdCode == CMD_RESUME && !susp_q |=> rspValid && rspError ##1 ceN)
    else $error("resume not refused outside suspend");

  a_query_gate: assert property (@(posedge clk_sys) disable iff (rst)
    accept && cmdCode == CMD_QUERY && (mode_q == MODE_BYPASS || mode_q == MODE_QUERY)
      |=> rspError && rspValid)
    else $error("parameter query not refused in wrong mode");

  a_read_single: assert property (@(posedge clk_sys) disable iff (rst)
    accept && legal && cmdCode == CMD_READ
      |=> ##[1:12] (rspValid && !rspError) ##0 $stable(mode_q))
    else $error("array read did not complete as one cycle");

  a_bypass_exit: assert property (@(posedge clk_sys) disable iff (rst)
    finish && (cmd_q == CMD_BYPASS_EXIT || cmd_q == CMD_RESET) |=> mode_q == MODE_READ)
    else $error("bypass exit did not restore array reading");

endmodule // nfc_flash_host

`default_nettype wire

// *** nfc_flash_model.sv ***
// Behavioural flash device that answers the host controller's pin cycles.
// Assumes strobes come from nfc_flash_host and that the ready line has a pull-up.
`default_nettype none
module nfc_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h00a5, // Arbitrary value
  parameter logic [15:0] PART_ID  = 16'h5a3c  // Arbitrary value
) (
  input  wire logic [19:0] flashAddr,
  input  wire logic [15:0] dqOut,
  input  wire logic        ceN,
  input  wire logic        weN,
  input  wire logic        oeN,
  output logic [15:0]      dqIn,
  output logic             flashReady
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Command decoder
  logic [15:0] mem [256];
  logic [19:0] aL;
  logic [15:0] last = 16'h0;
  int          st = 0;
  logic        idm = 0, byp = 0, qry = 0, busy = 0, sec = 0, sus = 0, hold, run;
  wire         wrS = ceN | weN;
  wire  [7:0]  cd = dqOut[7:0];
  wire  [10:0] ca = aL[10:0];
  wire  [1:0]  w = flashAddr[1:0];
  wire  [15:0] idv = w == 2'h0 ? MAKER_ID : w == 2'h1 ? PART_ID
                   : {8'h0, w == 2'h2 ? 8'h00 : 8'h8d};
  wire  [15:0] rv = qry ? 16'h0051 : idm ? idv : mem[flashAddr[7:0]];
  assign dqIn = (!ceN && !oeN) ? rv : ~last;
  assign flashReady = !busy;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  always @(posedge oeN) last = rv;
  always @(negedge wrS) aL = flashAddr;
  always @(posedge wrS) begin
    if (st == 3) mem[aL[7:0]] = dqOut;
    if (cd == 8'hf0) {idm, byp, qry} = 3'h0;
    if (st == 7) byp = cd != 8'h00;
    idm |= st == 2 && ca == 11'h555 && cd == 8'h90;
    byp |= st == 2 && ca == 11'h555 && cd == 8'h20;
    if (st == 0 && !byp && cd == 8'h00) idm = 1'b0;
    if (st == 0 && cd == 8'h98 && ca == 11'h055 && !busy) qry = 1'b1;
    if (st == 6 && cd == 8'h10 && ca == 11'h555) foreach (mem[i]) mem[i] = 16'hffff;
    sec = st == 6 ? cd == 8'h30 : sec;
    hold = st == 0 && sec && busy && cd == 8'hb0;
    run = (st == 6 && cd inside {8'h10, 8'h30}) || (st == 0 && sus && cd == 8'h30);
    sus = hold | (sus & !run);
    busy = run | (busy & !hold);
    if (run) busy <= #3000 1'b0;
    st = st == 3 ? 0 : byp && st == 0 ? (cd == 8'ha0 ? 3 : cd == 8'h90 ? 7 : 0)
       : st == 0 ? (ca == 11'h555 && cd == 8'haa ? 1 : 0)
       : st == 1 || st == 5 ? (ca == 11'h2aa && cd == 8'h55 ? st + 1 : 0)
       : st == 2 ? (ca != 11'h555 ? 0 : cd == 8'ha0 ? 3 : cd == 8'h80 ? 4 : 0)
       : st == 4 ? (ca == 11'h555 && cd == 8'haa ? 5 : 0) : 0;
  end
endmodule // nfc_flash_model
`default_nettype wire

// *** nfc_tb.sv ***
// Self-checking bench: host controller against the behavioural flash model.
// Assumes one 50 MHz clock and a synchronous active-high reset.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nfc_pkg::*;
  // ==========
  logic        clk_sys = 0, rst = 1, cmdValid = 0, timeoutExceeded = 0;
  nfc_cmd_t    cmdCode = CMD_READ;
  logic [19:0] cmdAddr = '0, flashAddr;
  logic [15:0] cmdData = '0, rspData, dqOut, dqIn;
  logic        cmdReady, rspValid, rspError, eraseRunning, eraseSuspended, secureRegion;
  logic        flashReady, dqDriveN, ceN, weN, oeN;
  nfc_mode_t   modeState;
  logic [16:0] rsp;
  int          miscompares = 0, cmp_count = 0;
  always #10 clk_sys = ~clk_sys;
  nfc_flash_host nfc_flash_host_inst (.*);
  nfc_flash_model nfc_flash_model_inst (.*);
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic ex(input nfc_cmd_t c, input logic [19:0] a, input logic [15:0] d,
                    input logic [16:0] e);
    int n;
    n = 0;
    cmdCode <= c;
    cmdAddr <= a;
    cmdData <= d;
    cmdValid <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (cmdReady !== 1'b1 && n < 99);
    cmdValid <= 1'b0;
    do begin @(posedge clk_sys); n++; end while (rspValid !== 1'b1 && n < 99);
    rsp = {rspError, rspData};
    check(n < 99 ? 17'h0 : 17'h1, 17'h0);
    if (n >= 99) wrap_up;
    check(e[16] ? {rsp[16], 16'h0} : rsp, e);
  endtask
  task automatic wait_done;
    int n;
    for (n = 0; eraseRunning !== 1'b0 && n < 300; n++) @(posedge clk_sys);
    check({16'h0, eraseRunning}, 17'h0);
    if (n >= 300) wrap_up;
  endtask
  task automatic t_array;
    ex(CMD_PROGRAM, 20'h00012, 16'h1234, 17'h0);
    ex(CMD_READ, 20'h00012, 0, 17'h01234);
    ex(CMD_READ, 20'h00013, 0, 17'h0ffff);
    ex(CMD_QUERY, 0, 0, 17'h0);
    ex(CMD_READ, 0, 0, 17'h00051);
    ex(CMD_RESET, 0, 0, 17'h0);
  endtask
  task automatic t_ident;
    ex(CMD_ID_READ, 20'h00000, 0, 17'h000a5);
    check({16'h0, modeState === MODE_ID}, 17'h1);
    ex(CMD_ID_READ, 20'h00001, 0, 17'h05a3c);
    ex(CMD_ID_READ, 20'h07002, 0, 17'h0);
    ex(CMD_ID_READ, 20'h00003, 0, 17'h0008d);
    ex(CMD_RESET, 0, 0, 17'h0);
    ex(CMD_READ, 20'h00012, 0, 17'h01234);
    ex(CMD_SECURE_ENTER, 0, 0, 17'h0);
    check({16'h0, secureRegion}, 17'h1);
    ex(CMD_SECURE_EXIT, 0, 0, 17'h0);
    check({16'h0, secureRegion}, 17'h0);
  endtask
  task automatic t_bypass;
    ex(CMD_BYPASS_ENTER, 0, 0, 17'h0);
    ex(CMD_BYPASS_PROGRAM, 20'h00020, 16'hbeef, 17'h0);
    ex(CMD_BYPASS_EXIT, 0, 0, 17'h0);
    check({16'h0, modeState === MODE_READ}, 17'h1);
    ex(CMD_READ, 20'h00020, 0, 17'h0beef);
    ex(CMD_BYPASS_ENTER, 0, 0, 17'h0);
    ex(CMD_QUERY, 20'h00055, 0, 17'h10000);
    ex(CMD_RESET, 0, 0, 17'h0);
    check({16'h0, modeState === MODE_READ}, 17'h1);
  endtask
  task automatic t_timeout;
    int n;
    ex(CMD_BYPASS_ENTER, 0, 0, 17'h0);
    timeoutExceeded <= 1'b1;
    for (n = 0; modeState !== MODE_READ && n < 40; n++) @(posedge clk_sys);
    timeoutExceeded <= 1'b0;
    check({16'h0, modeState === MODE_READ}, 17'h1);
    if (n >= 40) wrap_up;
    ex(CMD_PROGRAM, 20'h00030, 16'h5678, 17'h0);
    ex(CMD_READ, 20'h00030, 0, 17'h05678);
  endtask
  task automatic t_erase;
    ex(CMD_SUSPEND, 0, 0, 17'h10000);
    ex(CMD_SECTOR_ERASE, 20'h05000, 0, 17'h0);
    ex(CMD_SUSPEND, 0, 0, 17'h0);
    check({16'h0, eraseSuspended}, 17'h1);
    check({16'h0, eraseRunning}, 17'h1);
    ex(CMD_READ, 20'h00012, 0, 17'h01234);
    ex(CMD_READ, 20'h05012, 0, 17'h10000);
    ex(CMD_RESUME, 0, 0, 17'h0);
    check({16'h0, eraseRunning & !eraseSuspended}, 17'h1);
    ex(CMD_RESUME, 0, 0, 17'h10000);
    wait_done;
    ex(CMD_CHIP_ERASE, 0, 0, 17'h0);
    ex(CMD_SUSPEND, 0, 0, 17'h10000);
    wait_done;
    ex(CMD_READ, 20'h00012, 0, 17'h0ffff);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check({ceN, weN, oeN, dqDriveN, 13'h0}, 17'h1e000);
    t_array;
    t_ident;
    t_bypass;
    t_timeout;
    t_erase;
    wrap_up;
  end
endmodule // tb
`default_nettype wire
